// >>> parallel_slave_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
module parallel_slave_port_tb;
    typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;} psp_row_t;
    logic        REF_CLK = 1'b0;
    logic        RST_B = 1'b0;
    logic [7:0]  AWADDR = 8'h00, ARADDR = 8'h00;
    logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic [31:0] WDATA = 32'h0, RDATA;
    logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ, IRQ_PRIO_HIGH;
    logic [1:0]  BRESP, RRESP;
    logic [7:0]  DATA_IN, DATA_OUT, DATA_OE_B, cpu_data, q;
    logic [2:0]  CTRL_IN, CTRL_OUT, CTRL_OE_B, cpu_ctrl;
    int          n_errors = 0;
    int          n_tests = 0;
    localparam logic [1:0] OK = psp_pkg::RESP_OKAY;
    psp_row_t rows[16] = '{
        '{0, 8'h04, 8'h00, 8'h00, OK}, '{0, 8'h08, 8'h00, 8'hff, OK},
        '{0, 8'h10, 8'h00, 8'h00, OK}, '{0, 8'h14, 8'h00, 8'h07, OK},
        '{0, 8'h18, 8'h00, 8'h00, OK}, '{0, 8'h1c, 8'h00, 8'h00, OK},
        '{0, 8'h20, 8'h00, 8'h00, OK}, '{0, 8'h24, 8'h00, 8'h00, OK},
        '{0, 8'h28, 8'h00, 8'h00, OK}, '{0, 8'h30, 8'h00, 8'h00, OK},
        '{1, 8'h04, 8'ha5, 8'ha5, OK}, '{1, 8'h08, 8'h5a, 8'h5a, OK},
        '{1, 8'h10, 8'h05, 8'h05, OK}, '{1, 8'h24, 8'h80, 8'h80, OK},
        '{1, 8'h2c, 8'h07, 8'h00, OK}, '{1, 8'h34, 8'hff, 8'h00, psp_pkg::RESP_SLVERR}};

    always #2 REF_CLK = ~REF_CLK;
    // Pin level from the port's enables alone; CPU value wherever the port releases
    assign DATA_IN = (~DATA_OE_B & DATA_OUT) | (DATA_OE_B & cpu_data);
    assign CTRL_IN = (~CTRL_OE_B & CTRL_OUT) | (CTRL_OE_B & cpu_ctrl);

    psp_top u_psp_top (.REF_CLK(REF_CLK), .RST_B(RST_B), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hf), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE_B(DATA_OE_B), .CTRL_IN(CTRL_IN),
        .CTRL_OUT(CTRL_OUT), .CTRL_OE_B(CTRL_OE_B), .IRQ(IRQ), .IRQ_PRIO_HIGH(IRQ_PRIO_HIGH));
    psp_ext_cpu u_psp_ext_cpu (.clk(REF_CLK), .pin(DATA_IN), .ctrl(cpu_ctrl), .data(cpu_data));

    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = OK);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        AWADDR <= a;
        WDATA <= {24'h0, d};
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        while (aw || w) begin
            @(posedge REF_CLK);
            if (aw && AWREADY === 1'b1) begin
                aw = 1'b0;
                AWVALID <= 1'b0;
            end
            if (w && WREADY === 1'b1) begin
                w = 1'b0;
                WVALID <= 1'b0;
            end
        end
        while (BVALID !== 1'b1) @(posedge REF_CLK);
        BREADY <= 1'b0;
        chk("bresp", {30'h0, r}, {30'h0, BRESP});
        @(posedge REF_CLK);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r = OK);
        // Lets pin changes clear the two-stage sync first
        repeat (3) @(posedge REF_CLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        @(posedge REF_CLK);
        while (ARREADY !== 1'b1) @(posedge REF_CLK);
        ARVALID <= 1'b0;
        @(posedge REF_CLK);
        while (RVALID !== 1'b1) @(posedge REF_CLK);
        RREADY <= 1'b0;
        chk("rresp", {30'h0, r}, {30'h0, RRESP});
        chk($sformatf("reg %h", a), {24'h0, e}, RDATA);
    endtask

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge REF_CLK);
        n_errors++;
        report_and_stop();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge REF_CLK);
        RST_B <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) begin
                wr(rows[i].a, rows[i].d, rows[i].r);
            end
            rd(rows[i].a, rows[i].e, rows[i].r);
        end
        chk("data_oe", 8'h5a, DATA_OE_B);
        chk("prio", 1'b1, IRQ_PRIO_HIGH);
        wr(8'h08, 8'h00);
        rd(8'h00, 8'ha5);
        rd(8'h0c, 8'h00);
        wr(8'h18, 8'h07);
        wr(8'h14, 8'h00);
        chk("ctrl_oe", 3'h0, CTRL_OE_B);
        rd(8'h0c, 8'h05);
        wr(8'h14, 8'h17);
        chk("ctrl_oe", 3'h7, CTRL_OE_B);
        chk("data_oe", 8'hff, DATA_OE_B);
        wr(8'h30, 8'h07);
        wr(8'h20, 8'h80);
        u_psp_ext_cpu.xfer(1'b1, 1'b1, 8'hc3, q);
        chk("irq", 1'b1, IRQ);
        rd(8'h28, 8'h02);
        rd(8'h14, 8'h97);
        rd(8'h1c, 8'h80);
        rd(8'h00, 8'hc3);
        rd(8'h14, 8'h17);
        wr(8'h30, 8'h00);
        wr(8'h20, 8'h00);
        chk("irq", 1'b0, IRQ);
        wr(8'h30, 8'h02);
        chk("irq", 1'b1, IRQ);
        wr(8'h2c, 8'h07);
        wr(8'h1c, 8'h00);
        chk("irq", 1'b0, IRQ);
        u_psp_ext_cpu.xfer(1'b1, 1'b1, 8'h11, q);
        u_psp_ext_cpu.xfer(1'b1, 1'b1, 8'h22, q);
        rd(8'h14, 8'hb7);
        rd(8'h28, 8'h06);
        rd(8'h00, 8'h22);
        wr(8'h2c, 8'h07);
        wr(8'h14, 8'h17);
        wr(8'h00, 8'h6b);
        rd(8'h14, 8'h57);
        u_psp_ext_cpu.xfer(1'b0, 1'b1, 8'h00, q);
        chk("ext_read", 8'h6b, q);
        rd(8'h14, 8'h17);
        rd(8'h28, 8'h01);
        wr(8'h2c, 8'h07);
        u_psp_ext_cpu.xfer(1'b1, 1'b0, 8'h99, q);
        u_psp_ext_cpu.xfer(1'b0, 1'b0, 8'h00, q);
        rd(8'h28, 8'h00);
        rd(8'h14, 8'h17);
        RST_B <= 1'b0;
        repeat (2) @(posedge REF_CLK);
        chk("data_oe", 8'hff, DATA_OE_B);
        chk("ctrl_oe", 3'h7, CTRL_OE_B);
        chk("irq", 1'b0, IRQ);
        RST_B <= 1'b1;
        @(posedge REF_CLK);
        rd(8'h14, 8'h07);
        report_and_stop();
    end
endmodule
`default_nettype wire

// >>> psp_ext_cpu.sv
`timescale 1ns/100ps
`default_nettype none
module psp_ext_cpu (
    input  wire logic       clk,
    input  wire logic [7:0] pin,
    output logic      [2:0] ctrl,
    output logic      [7:0] data
);
    logic       drv_q;
    logic [7:0] val_q;
    logic [7:0] idle_q;

    initial begin
        ctrl = 3'h7;
        drv_q = 1'b0;
        val_q = 8'h00;
        idle_q = 8'h00;
    end

    // Released bus keeps changing so stale data never passes
    always @(posedge clk) begin
        idle_q <= ~idle_q;
    end
    assign data = drv_q ? val_q : idle_q;

    // ****************************************
    // One external bus cycle
    // ****************************************
    task automatic xfer(input logic wr, input logic sel, input logic [7:0] d,
                        output logic [7:0] q);
        drv_q <= wr;
        val_q <= d;
        @(posedge clk);
        ctrl <= {~sel, ~wr, wr};
        repeat (6) @(posedge clk);
        q = pin;
        ctrl <= 3'h7;
        // Data held past the strobe so the far end syncs it
        repeat (3) @(posedge clk);
        drv_q <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// >>> psp_pkg.sv
// Functional notes
// - Mode bit set makes data port slave port
// - External strobes alone drive slave-port transfers
// - Mode bit turns control pins into strobes
// - Write starts when select and write low
// - Read starts when select and read low
// - Low read strobe returns data-port latch
// - Low write strobe loads data-port latch
// - Select high means strobes are ignored
// - Outside sees one readable writable latch; code loads writes into in_latch_q and returns dlatch_q on reads
// - Mode clear gives plain pins or analog
// - Internal write loads latch, read returns pins; with mode bit set the code returns in_latch_q instead
package psp_pkg;

    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [7:0] OFF_DATA_PORT    = 8'h00;
    localparam logic [7:0] OFF_DATA_LATCH   = 8'h04;
    localparam logic [7:0] OFF_DATA_DIR     = 8'h08;
    localparam logic [7:0] OFF_CTRL_PINS    = 8'h0c;
    localparam logic [7:0] OFF_CTRL_LATCH   = 8'h10;
    localparam logic [7:0] OFF_CTRL_DIRMODE = 8'h14;
    localparam logic [7:0] OFF_ANALOG_CFG   = 8'h18;
    localparam logic [7:0] OFF_PERIPH_FLAGS = 8'h1c;
    localparam logic [7:0] OFF_PERIPH_ENS   = 8'h20;
    localparam logic [7:0] OFF_PERIPH_PRIO  = 8'h24;
    localparam logic [7:0] OFF_INT_STATUS   = 8'h28;
    localparam logic [7:0] OFF_INT_CLEAR    = 8'h2c;
    localparam logic [7:0] OFF_INT_ENABLE   = 8'h30;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RST_DATA_LATCH   = 8'h00;
    localparam logic [7:0] RST_DATA_DIR     = 8'hff;
    localparam logic [2:0] RST_CTRL_LATCH   = 3'h0;
    localparam logic [7:0] RST_CTRL_DIRMODE = 8'h07;
    localparam logic [7:0] RST_ANALOG_CFG   = 8'h00;
    localparam logic [7:0] RST_PERIPH       = 8'h00;
    localparam logic [2:0] RST_INT          = 3'h0;

    // ****************************************
    // Field positions and masks
    // ****************************************
    localparam int         BIT_IN_FULL      = 7;
    localparam int         BIT_OUT_FULL     = 6;
    localparam int         BIT_IN_OVERFLOW  = 5;
    localparam int         BIT_MODE_SELECT  = 4;
    localparam int         BIT_SLAVE_INT    = 7;
    localparam int         BIT_CTRL_RD      = 0;
    localparam int         BIT_CTRL_WR      = 1;
    localparam int         BIT_CTRL_CS      = 2;
    localparam logic [7:0] MASK_ANALOG_CFG  = 8'hcf;
    localparam logic [2:0] PCFG_ALL_DIGITAL = 3'h7;
    localparam int         EV_EXT_READ      = 0;
    localparam int         EV_EXT_WRITE     = 1;
    localparam int         EV_OVERFLOW      = 2;

    // ****************************************
    // Bus answers
    // ****************************************
    localparam logic [1:0] RESP_OKAY        = 2'h0;
    localparam logic [1:0] RESP_SLVERR      = 2'h2;

endpackage

// >>> psp_sync.sv
`timescale 1ns/100ps
`default_nettype none
module psp_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    // Two stages; only the second is read outside
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// >>> psp_top.sv
`timescale 1ns/100ps
`default_nettype none
module psp_top (
    input  wire logic        REF_CLK,
    input  wire logic        RST_B,
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    input  wire logic [7:0]  DATA_IN,
    output logic [7:0]       DATA_OUT,
    output logic [7:0]       DATA_OE_B,
    input  wire logic [2:0]  CTRL_IN,
    output logic [2:0]       CTRL_OUT,
    output logic [2:0]       CTRL_OE_B,
    output logic             IRQ,
    output logic             IRQ_PRIO_HIGH
);

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        PSP_WS_COLLECT = 2'b01,
        PSP_WS_RESP    = 2'b10
    } psp_wstate_t;

    typedef enum logic [1:0] {
        PSP_RS_IDLE = 2'b01,
        PSP_RS_DATA = 2'b10
    } psp_rstate_t;

    // ****************************************
    // Declarations
    // ****************************************
    psp_wstate_t ws_q;
    psp_rstate_t rs_q;
    logic        aw_got_q;
    logic        w_got_q;
    logic [7:0]  awaddr_q;
    logic [7:0]  wbyte_q;
    logic        wlane_q;
    logic        aw_have;
    logic        w_have;
    logic [7:0]  wa;
    logic [7:0]  wd;
    logic        wl;
    logic        wr_fire;
    logic        wr_hit;
    logic        rd_fire;
    logic        rd_hit;
    logic [7:0]  rd_byte;
    logic        sw_wr_port;
    logic        sw_rd_port;
    logic [7:0]  data_s;
    logic [2:0]  ctrl_s;
    logic        mode;
    logic        ctrl_digital;
    logic        sel_s;
    logic        rd_start;
    logic        rd_done;
    logic        rd_busy;
    logic        wr_start;
    logic        wr_done;
    logic        wr_busy;
    logic [7:0]  dlatch_q;
    logic [7:0]  ddir_q;
    logic [2:0]  late_q;
    logic [7:0]  cdir_q;
    logic [7:0]  adcon_q;
    logic [7:0]  pir_q;
    logic [7:0]  pie_q;
    logic [7:0]  ipr_q;
    logic [7:0]  in_latch_q;
    logic        in_full_q;
    logic        out_full_q;
    logic        in_ovf_q;
    logic        rd_drive_q;
    logic [2:0]  int_stat_q;
    logic [2:0]  int_en_q;
    logic [2:0]  int_ev;
    logic [2:0]  ctrl_rd;
    logic [7:0]  cdir_rd;

    // ****************************************
    // Pin synchronisers and transfer detection
    // ****************************************
    psp_sync #(.W(11)) u_sync (
        .clk   (REF_CLK),
        .rst_b (RST_B),
        .d     ({CTRL_IN, DATA_IN}),
        .q     ({ctrl_s, data_s})
    );

    assign mode  = cdir_q[psp_pkg::BIT_MODE_SELECT];
    assign sel_s = ~ctrl_s[psp_pkg::BIT_CTRL_CS];

    // Strobes alone pace transfers; sync adds two cycles of latency
    psp_xfer_det u_rd_det (
        .clk    (REF_CLK),
        .rst_b  (RST_B),
        .en     (mode),
        .active (sel_s & ~ctrl_s[psp_pkg::BIT_CTRL_RD]),
        .start  (rd_start),
        .done   (rd_done),
        .busy_q (rd_busy)
    );

    psp_xfer_det u_wr_det (
        .clk    (REF_CLK),
        .rst_b  (RST_B),
        .en     (mode),
        .active (sel_s & ~ctrl_s[psp_pkg::BIT_CTRL_WR]),
        .start  (wr_start),
        .done   (wr_done),
        .busy_q (wr_busy)
    );

    // ****************************************
    // Bus write channel
    // ****************************************
    assign AWREADY = (ws_q == PSP_WS_COLLECT) & ~aw_got_q;
    assign WREADY  = (ws_q == PSP_WS_COLLECT) & ~w_got_q;
    assign BVALID  = (ws_q == PSP_WS_RESP);
    assign aw_have = aw_got_q | (AWVALID & AWREADY);
    assign w_have  = w_got_q | (WVALID & WREADY);
    assign wa      = aw_got_q ? awaddr_q : AWADDR;
    assign wd      = w_got_q ? wbyte_q : WDATA[7:0];
    assign wl      = w_got_q ? wlane_q : WSTRB[0];
    assign wr_fire = (ws_q == PSP_WS_COLLECT) & aw_have & w_have;
    assign wr_hit  = (wa[7:2] <= psp_pkg::OFF_INT_ENABLE[7:2]);

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            ws_q     <= PSP_WS_COLLECT;
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            awaddr_q <= 8'h00;
            wbyte_q  <= 8'h00;
            wlane_q  <= 1'b0;
            BRESP    <= psp_pkg::RESP_OKAY;
        end else begin
            case (ws_q)
                PSP_WS_COLLECT: begin
                    if (AWVALID & AWREADY) begin
                        aw_got_q <= 1'b1;
                        awaddr_q <= AWADDR;
                    end
                    if (WVALID & WREADY) begin
                        w_got_q <= 1'b1;
                        wbyte_q <= WDATA[7:0];
                        wlane_q <= WSTRB[0];
                    end
                    if (wr_fire) begin
                        ws_q     <= PSP_WS_RESP;
                        aw_got_q <= 1'b0;
                        w_got_q  <= 1'b0;
                        BRESP    <= wr_hit ? psp_pkg::RESP_OKAY : psp_pkg::RESP_SLVERR;
                    end
                end
                PSP_WS_RESP: begin
                    if (BREADY) begin
                        ws_q <= PSP_WS_COLLECT;
                    end
                end
                default: begin
                    ws_q <= PSP_WS_COLLECT;
                end
            endcase
        end
    end

    function automatic logic wr_to(input logic [7:0] off);
        wr_to = wr_fire & wl & (wa[7:2] == off[7:2]);
    endfunction

    assign sw_wr_port = wr_to(psp_pkg::OFF_DATA_PORT);

    // ****************************************
    // Bus read channel
    // ****************************************
    assign ARREADY = (rs_q == PSP_RS_IDLE);
    assign RVALID  = (rs_q == PSP_RS_DATA);
    assign rd_fire = ARVALID & ARREADY;
    assign rd_hit  = (ARADDR[7:2] <= psp_pkg::OFF_INT_ENABLE[7:2]);
    assign sw_rd_port = rd_fire & (ARADDR[7:2] == psp_pkg::OFF_DATA_PORT[7:2]);

    // Analog-selected control pins read as zero
    assign ctrl_digital = (adcon_q[2:0] == psp_pkg::PCFG_ALL_DIGITAL);
    assign ctrl_rd      = ctrl_digital ? ctrl_s : 3'h0;
    assign cdir_rd      = {in_full_q, out_full_q, in_ovf_q, mode, 1'b0, cdir_q[2:0]};

    always_comb begin
        case (ARADDR[7:2])
            psp_pkg::OFF_DATA_PORT[7:2]:    rd_byte = mode ? in_latch_q : data_s;
            psp_pkg::OFF_DATA_LATCH[7:2]:   rd_byte = dlatch_q;
            psp_pkg::OFF_DATA_DIR[7:2]:     rd_byte = ddir_q;
            psp_pkg::OFF_CTRL_PINS[7:2]:    rd_byte = {5'h00, ctrl_rd};
            psp_pkg::OFF_CTRL_LATCH[7:2]:   rd_byte = {5'h00, late_q};
            psp_pkg::OFF_CTRL_DIRMODE[7:2]: rd_byte = cdir_rd;
            psp_pkg::OFF_ANALOG_CFG[7:2]:   rd_byte = adcon_q;
            psp_pkg::OFF_PERIPH_FLAGS[7:2]: rd_byte = pir_q;
            psp_pkg::OFF_PERIPH_ENS[7:2]:   rd_byte = pie_q;
            psp_pkg::OFF_PERIPH_PRIO[7:2]:  rd_byte = ipr_q;
            psp_pkg::OFF_INT_STATUS[7:2]:   rd_byte = {5'h00, int_stat_q};
            psp_pkg::OFF_INT_ENABLE[7:2]:   rd_byte = {5'h00, int_en_q};
            default:                        rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            rs_q  <= PSP_RS_IDLE;
            RDATA <= 32'h0000_0000;
            RRESP <= psp_pkg::RESP_OKAY;
        end else begin
            case (rs_q)
                PSP_RS_IDLE: begin
                    if (rd_fire) begin
                        rs_q  <= PSP_RS_DATA;
                        RDATA <= {24'h00_0000, rd_byte};
                        RRESP <= rd_hit ? psp_pkg::RESP_OKAY : psp_pkg::RESP_SLVERR;
                    end
                end
                PSP_RS_DATA: begin
                    if (RREADY) begin
                        rs_q <= PSP_RS_IDLE;
                    end
                end
                default: begin
                    rs_q <= PSP_RS_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Port configuration registers
    // ****************************************
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            dlatch_q <= psp_pkg::RST_DATA_LATCH;
            ddir_q   <= psp_pkg::RST_DATA_DIR;
            late_q   <= psp_pkg::RST_CTRL_LATCH;
            cdir_q   <= psp_pkg::RST_CTRL_DIRMODE;
            adcon_q <= psp_pkg::RST_ANALOG_CFG;
            pie_q   <= psp_pkg::RST_PERIPH;
            ipr_q   <= psp_pkg::RST_PERIPH;
        end else begin
            if (sw_wr_port | wr_to(psp_pkg::OFF_DATA_LATCH)) begin
                dlatch_q <= wd;
            end
            if (wr_to(psp_pkg::OFF_DATA_DIR)) begin
                ddir_q <= wd;
            end
            if (wr_to(psp_pkg::OFF_CTRL_PINS) | wr_to(psp_pkg::OFF_CTRL_LATCH)) begin
                late_q <= wd[2:0];
            end
            // Upper status bits live in their own flops
            if (wr_to(psp_pkg::OFF_CTRL_DIRMODE)) begin
                cdir_q <= wd & 8'h17;
            end
            if (wr_to(psp_pkg::OFF_ANALOG_CFG)) begin
                adcon_q <= wd & psp_pkg::MASK_ANALOG_CFG;
            end
            if (wr_to(psp_pkg::OFF_PERIPH_ENS)) begin
                pie_q <= wd;
            end
            if (wr_to(psp_pkg::OFF_PERIPH_PRIO)) begin
                ipr_q <= wd;
            end
        end
    end

    // ****************************************
    // Slave-port latch and buffer flags
    // ****************************************
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            in_latch_q <= 8'h00;
        end else if (wr_start) begin
            in_latch_q <= data_s;
        end
    end

    // Set always wins over a same-cycle clear
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            in_full_q  <= 1'b0;
            out_full_q <= 1'b0;
            in_ovf_q   <= 1'b0;
        end else begin
            in_full_q  <= wr_start | (in_full_q & ~sw_rd_port);
            out_full_q <= (sw_wr_port & mode) | (out_full_q & ~rd_done);
            if (wr_start & in_full_q) begin
                in_ovf_q <= 1'b1;
            end else if (wr_to(psp_pkg::OFF_CTRL_DIRMODE)) begin
                in_ovf_q <= wd[psp_pkg::BIT_IN_OVERFLOW];
            end
        end
    end

    // ****************************************
    // Pin drivers
    // ****************************************
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            rd_drive_q <= 1'b0;
        end else begin
            rd_drive_q <= rd_start | (rd_busy & ~rd_done);
        end
    end

    assign DATA_OUT  = dlatch_q;
    // Slave port overrides the direction register: drive only during a read
    assign DATA_OE_B = mode ? {8{~rd_drive_q}} : ddir_q;
    assign CTRL_OUT  = late_q;
    assign CTRL_OE_B = mode ? 3'h7 : cdir_q[2:0];

    // ****************************************
    // Interrupts
    // ****************************************
    assign int_ev = {wr_start & in_full_q, wr_start, rd_done};

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            pir_q <= psp_pkg::RST_PERIPH;
        end else begin
            if (wr_to(psp_pkg::OFF_PERIPH_FLAGS)) begin
                pir_q <= wd;
            end
            if (wr_start | rd_done) begin
                pir_q[psp_pkg::BIT_SLAVE_INT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            int_stat_q <= psp_pkg::RST_INT;
            int_en_q   <= psp_pkg::RST_INT;
        end else begin
            if (wr_to(psp_pkg::OFF_INT_ENABLE)) begin
                int_en_q <= wd[2:0];
            end
            if (wr_to(psp_pkg::OFF_INT_CLEAR)) begin
                int_stat_q <= (int_stat_q & ~wd[2:0]) | int_ev;
            end else begin
                int_stat_q <= int_stat_q | int_ev;
            end
        end
    end

    assign IRQ = |(int_stat_q & int_en_q) |
                 (pir_q[psp_pkg::BIT_SLAVE_INT] & pie_q[psp_pkg::BIT_SLAVE_INT]);
    assign IRQ_PRIO_HIGH = ipr_q[psp_pkg::BIT_SLAVE_INT];

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    sequence s_wr_begin;
        mode & sel_s & ~ctrl_s[psp_pkg::BIT_CTRL_WR] & ~wr_busy;
    endsequence

    sequence s_rd_begin;
        mode & sel_s & ~ctrl_s[psp_pkg::BIT_CTRL_RD] & ~rd_busy;
    endsequence

    a_io_no_xfer: assert property (!mode |-> !wr_start && !rd_start)
        else $error("transfer seen outside slave-port mode");
    a_mode_pins_in: assert property (mode |-> CTRL_OE_B == 3'h7)
        else $error("control pins driven in slave-port mode");
    a_wr_capture: assert property (s_wr_begin |=> in_full_q && in_latch_q == $past(data_s))
        else $error("write strobe did not capture data");
    a_rd_drive: assert property (s_rd_begin |=> DATA_OE_B == 8'h00 && DATA_OUT == dlatch_q)
        else $error("read strobe did not drive latch");
    a_rd_release: assert property (mode && rd_done |=> DATA_OE_B == 8'hff)
        else $error("data port still driven after read");
    a_unselected: assert property (!sel_s |-> !wr_start && !rd_start)
        else $error("strobe honoured without chip select");
    a_io_dir: assert property (!mode |-> CTRL_OE_B == cdir_q[2:0] && DATA_OE_B == ddir_q)
        else $error("plain port direction wrong");
    a_sw_latch: assert property (sw_wr_port |=> dlatch_q == $past(wd))
        else $error("data latch not loaded by bus write");
    a_flag_set: assert property (wr_start || rd_done |=> pir_q[psp_pkg::BIT_SLAVE_INT] ##1
                                  (!pie_q[psp_pkg::BIT_SLAVE_INT] || IRQ))
        else $error("transfer flag or interrupt missing");

endmodule
`default_nettype wire

// >>> psp_xfer_det.sv
`timescale 1ns/100ps
`default_nettype none
module psp_xfer_det (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic en,
    input  wire logic active,
    output logic      start,
    output logic      done,
    output logic      busy_q
);
    logic live;

    assign live  = en & active;
    // First cycle the strobe pair is seen low
    assign start = live & ~busy_q;
    assign done  = busy_q & ~live;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= live;
        end
    end
endmodule
`default_nettype wire
